// file: rtl/uafc_cfg.svh
`ifndef UAFC_CFG_SVH
`define UAFC_CFG_SVH
// modem control bit positions
`define UAFC_MODEM_RTS_BIT 1
`define UAFC_MODEM_AUTOFLOW_BIT 5
// receive trigger level encodings
`define UAFC_TRIG_1 2'h0
`define UAFC_TRIG_4 2'h1
`define UAFC_TRIG_8 2'h2
`define UAFC_TRIG_14 2'h3
`define UAFC_LVL_1 5'h01
`define UAFC_LVL_4 5'h04
`define UAFC_LVL_8 5'h08
`define UAFC_RX_CAP 5'h10
`define UAFC_RX_LAST 5'h0F
`define UAFC_RX_EMPTY 5'h00
`define UAFC_CNT_W 5
// transmit data fifo
`define UAFC_FIFO_W 8
`define UAFC_FIFO_D 32
`define UAFC_FIFO_AW 5
`endif

// file: rtl/uafc_pkg.sv
package uafc_pkg;
   // modem control bits that steer flow control
   typedef struct packed {
      logic autoflow_enable;
      logic rts;
   } uafc_modem_ctl_t;
   // receive fifo status seen by the flow logic
   typedef struct packed {
      logic [4:0] fill;
      logic [1:0] trig;
      logic rx_first_data;
   } uafc_rx_t;
endpackage : uafc_pkg

// file: rtl/uafc_fifo.sv
`timescale 1ns/10ps
module uafc_fifo #(
   parameter int W = 8,
   parameter int D = 32,
   parameter int AW = 5
) (
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire logic [W-1:0] in_data, // write data
   input wire logic in_valid, // write request
   output logic in_ready, // not full
   output logic [W-1:0] out_data, // head word
   output logic out_valid, // not empty
   input wire logic out_ready // pop
);
   logic [W-1:0] mem [D];
   logic [AW:0] wp_q;
   logic [AW:0] rp_q;
   logic full;
   logic empty;
   assign empty = (wp_q == rp_q);
   assign full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rp_q[AW-1:0]];
   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wp_q[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q <= '0;
      end else if (in_valid && !full) begin
         wp_q <= wp_q + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         rp_q <= '0;
      end else if (out_ready && !empty) begin
         rp_q <= rp_q + 1'b1;
      end
   end
endmodule : uafc_fifo

// file: rtl/uafc_top.sv
// What this block does
// - with auto cts, sample cts before each character; start only when active
// - cts changes raise no host interrupt while autoflow is enabled
// - without auto cts, send whatever the transmit fifo holds
// - autoflow enable plus rts bit turns on auto rts and auto cts
// - autoflow enable with rts bit clear gives auto cts only
// - trigger 1, 4 or 8: rts drops when fill reaches trigger
// - trigger 1, 4 or 8: rts returns only after fifo empties
// - trigger 14: drop at first data bit of 16th char, return when space
`timescale 1ns/10ps
`include "uafc_cfg.svh"
module uafc_top (
   input wire logic clk, // 20 MHz clock
   input wire logic rst, // sync reset, active high
   input wire uafc_pkg::uafc_modem_ctl_t modem_control_register, // autoflow and rts bits
   input wire uafc_pkg::uafc_rx_t rx_stat, // receive_fifo state
   input wire logic cts_n, // clear to send pin, active low
   input wire logic [7:0] tx_data, // byte from host
   input wire logic tx_valid, // host byte valid
   output logic tx_ready, // transmit fifo has room
   output logic [7:0] chr_data, // byte to serialiser
   output logic chr_start, // one-cycle start of a character
   input wire logic chr_idle, // serialiser can take a character
   output logic rts_n_q, // request to send pin, active low
   output logic cts_delta_q // cts change flag for host interrupt
);
   // ----------------------------------------------------------------
   // cts synchroniser
   // ----------------------------------------------------------------
   logic cts_m_q;
   logic cts_s_q;
   logic cts_old_q;
   // reset to the idle high level so no false change follows reset
   always_ff @(posedge clk) begin
      if (rst) begin
         cts_m_q <= 1'b1;
         cts_s_q <= 1'b1;
         cts_old_q <= 1'b1;
      end else begin
         cts_m_q <= cts_n;
         cts_s_q <= cts_m_q;
         cts_old_q <= cts_s_q;
      end
   end
   logic auto_cts;
   logic auto_rts;
   assign auto_cts = modem_control_register.autoflow_enable;
   assign auto_rts = modem_control_register.autoflow_enable && modem_control_register.rts;
   // ----------------------------------------------------------------
   // cts change flag, suppressed under autoflow
   // ----------------------------------------------------------------
   // both sides of the compare are synchronised, so a metastable
   // first stage never reaches the flag
   always_ff @(posedge clk) begin
      if (rst) begin
         cts_delta_q <= 1'b0;
      end else if (!auto_cts && (cts_s_q != cts_old_q)) begin
         cts_delta_q <= 1'b1;
      end else begin
         cts_delta_q <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // transmit fifo and start gate
   // ----------------------------------------------------------------
   logic [7:0] head;
   logic head_valid;
   logic go;
   // the start gate samples cts only at character boundaries, so a drop
   // that has passed the synchroniser by then holds the next one back
   assign go = head_valid && chr_idle && !chr_start && (!auto_cts || !cts_s_q);
   uafc_fifo #(
      .W(`UAFC_FIFO_W),
      .D(`UAFC_FIFO_D),
      .AW(`UAFC_FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(head),
      .out_valid(head_valid),
      .out_ready(go)
   );
   always_ff @(posedge clk) begin
      if (rst) begin
         chr_start <= 1'b0;
         chr_data <= 8'h00;
      end else begin
         chr_start <= go;
         if (go) begin
            chr_data <= head;
         end
      end
   end
   // ----------------------------------------------------------------
   // auto rts
   // ----------------------------------------------------------------
   // trigger 8 and 14 share the default arm of the level decode;
   // trigger 14 takes its own path in the hold logic
   logic [4:0] lvl;
   logic hold_q;
   logic armed_q;
   always_comb begin
      case (rx_stat.trig)
         `UAFC_TRIG_1: lvl = `UAFC_LVL_1;
         `UAFC_TRIG_4: lvl = `UAFC_LVL_4;
         default: lvl = `UAFC_LVL_8;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_q <= 1'b0;
      end else if (rx_stat.trig == `UAFC_TRIG_14) begin
         if (rx_stat.fill == `UAFC_RX_CAP) begin
            hold_q <= 1'b1;
         end else if (rx_stat.fill == `UAFC_RX_LAST && rx_stat.rx_first_data) begin
            hold_q <= 1'b1;
         end else if (rx_stat.fill < `UAFC_RX_LAST || !armed_q) begin
            hold_q <= 1'b0;
         end
      end else if (rx_stat.fill >= lvl) begin
         hold_q <= 1'b1;
      end else if (rx_stat.fill == `UAFC_RX_EMPTY) begin
         hold_q <= 1'b0;
      end
   end
   // a drop taken on the first data bit at fill 15 must outlast that
   // character; a drop taken at full ends with the first read, as one
   // byte of space is then open
   always_ff @(posedge clk) begin
      if (rst) begin
         armed_q <= 1'b0;
      end else if (rx_stat.trig == `UAFC_TRIG_14 && rx_stat.fill == `UAFC_RX_LAST
         && rx_stat.rx_first_data) begin
         armed_q <= 1'b1;
      end else if (rx_stat.trig != `UAFC_TRIG_14 || rx_stat.fill != `UAFC_RX_LAST) begin
         armed_q <= 1'b0;
      end
   end
   // registered so the pin cannot glitch while the fill count settles;
   // costs one cycle of lag behind the hold decision
   always_ff @(posedge clk) begin
      if (rst) begin
         rts_n_q <= 1'b1;
      end else if (auto_rts) begin
         rts_n_q <= hold_q;
      end else begin
         rts_n_q <= !modem_control_register.rts;
      end
   end
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_start_gated: assert property (@(posedge clk) disable iff (rst)
      chr_start && $past(auto_cts) |-> !$past(cts_s_q))
      else $error("character started while cts inactive");
   chk_no_irq_auto: assert property (@(posedge clk) disable iff (rst)
      $past(auto_cts) |-> !cts_delta_q)
      else $error("cts change flagged under autoflow");
   chk_free_send: assert property (@(posedge clk) disable iff (rst)
      !auto_cts && head_valid && chr_idle && !chr_start |=> chr_start)
      else $error("transmit stalled without auto cts");
   chk_trig_drop: assert property (@(posedge clk) disable iff (rst)
      auto_rts && rx_stat.trig != `UAFC_TRIG_14 && rx_stat.fill >= lvl
      ##1 auto_rts |=> rts_n_q)
      else $error("rts not dropped at trigger");
   chk_empty_rise: assert property (@(posedge clk) disable iff (rst)
      hold_q && rx_stat.trig != `UAFC_TRIG_14 && rx_stat.fill != 5'h00 |=> hold_q)
      else $error("rts released before empty");
   chk_full_drop: assert property (@(posedge clk) disable iff (rst)
      rx_stat.trig == `UAFC_TRIG_14 && rx_stat.fill == `UAFC_RX_CAP |=> hold_q)
      else $error("rts not held with fifo full");
   chk_auto_off: assert property (@(posedge clk) disable iff (rst)
      !auto_rts |=> rts_n_q == !$past(modem_control_register.rts))
      else $error("rts pin not following control bit");
   chk_sync_lag: assert property (@(posedge clk) disable iff (rst)
      ##2 cts_s_q == $past(cts_n, 2))
      else $error("cts synchroniser lag wrong");
   // ----------------------------------------------------------------
   // checks on start pulse, change flag and rts hold
   // ----------------------------------------------------------------
   // the trigger 14 hold checks read hold_q so that a fault is pinned to the stage
   // that made it, not to the pin it reaches later
   chk_space_rise: assert property (@(posedge clk) disable iff (rst)
      rx_stat.trig == `UAFC_TRIG_14 && $past(rx_stat.fill) == `UAFC_RX_CAP
      && rx_stat.fill < `UAFC_RX_CAP && !rx_stat.rx_first_data |=> !hold_q)
      else $error("rts held with space free");
   chk_first_drop: assert property (@(posedge clk) disable iff (rst)
      rx_stat.trig == `UAFC_TRIG_14 && rx_stat.fill == `UAFC_RX_LAST
      && rx_stat.rx_first_data |=> hold_q)
      else $error("rts not dropped on first data bit");
   chk_low_release: assert property (@(posedge clk) disable iff (rst)
      rx_stat.trig == `UAFC_TRIG_14 && rx_stat.fill < `UAFC_RX_LAST |=> !hold_q)
      else $error("rts held with fifo below fifteen");
   chk_drain_rise: assert property (@(posedge clk) disable iff (rst)
      auto_rts && rx_stat.trig != `UAFC_TRIG_14 && rx_stat.fill == `UAFC_RX_EMPTY
      ##1 auto_rts |=> !rts_n_q)
      else $error("rts not restored after drain");
   chk_delta_flag: assert property (@(posedge clk) disable iff (rst)
      !auto_cts && cts_s_q != cts_old_q |=> cts_delta_q)
      else $error("cts change not flagged");
   chk_start_pulse: assert property (@(posedge clk) disable iff (rst)
      chr_start |=> !chr_start)
      else $error("character start longer than one cycle");
   chk_data_steady: assert property (@(posedge clk) disable iff (rst)
      !chr_start |-> $stable(chr_data))
      else $error("character byte moved without a start");
   chk_idle_start: assert property (@(posedge clk) disable iff (rst)
      chr_start |-> $past(chr_idle))
      else $error("character started while serialiser busy");
   chk_cts_only: assert property (@(posedge clk) disable iff (rst)
      auto_cts && !modem_control_register.rts |=> rts_n_q)
      else $error("rts pin active with auto cts only");
   chk_rts_follow: assert property (@(posedge clk) disable iff (rst)
      auto_rts |=> rts_n_q == $past(hold_q))
      else $error("rts pin not following hold under auto rts");
endmodule : uafc_top

// file: test/uafc_remote.sv
`timescale 1ns/10ps
module uafc_remote (
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire logic chr_start, // character launched
   input wire logic cts_hold, // bench asks the far end to pause us
   output logic chr_idle, // serialiser free
   output logic cts_n // clear to send, active low
);
   logic [2:0] busy_q;
   // short frame keeps the run brief, still drops idle the cycle after a start
   always_ff @(posedge clk) begin
      if (rst)
         busy_q <= 3'h0;
      else if (chr_start)
         busy_q <= 3'h5;
      else if (busy_q != 3'h0)
         busy_q <= busy_q - 3'h1;
   end
   assign chr_idle = (busy_q == 3'h0);
   always_ff @(posedge clk) begin
      cts_n <= rst ? 1'b1 : cts_hold;
   end
endmodule : uafc_remote

// file: test/uafc_top_bench.sv
`timescale 1ns/10ps
module uafc_top_bench;
   logic clk, rst, tx_valid, tx_ready, chr_start, chr_idle, rts_n_q, cts_delta_q;
   logic cts_n, cts_hold;
   logic [7:0] tx_data, chr_data, last;
   logic [1:0] trg;
   uafc_pkg::uafc_modem_ctl_t modem_ctl;
   uafc_pkg::uafc_rx_t rx_stat;
   int num_errors = 0, cmp_count = 0, n_start = 0, n_delta = 0, b;
   uafc_top DUT (.clk(clk), .rst(rst), .modem_control_register(modem_ctl), .rx_stat(rx_stat),
      .cts_n(cts_n), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .chr_data(chr_data), .chr_start(chr_start), .chr_idle(chr_idle), .rts_n_q(rts_n_q),
      .cts_delta_q(cts_delta_q));
   uafc_remote far (.clk(clk), .rst(rst), .chr_start(chr_start), .cts_hold(cts_hold),
      .chr_idle(chr_idle), .cts_n(cts_n));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (chr_start === 1'b1) begin
         n_start++;
         last = chr_data;
      end
      if (cts_delta_q === 1'b1)
         n_delta++;
   end
   task automatic give_verdict();
      if (num_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic hang(input int i, input int lim);
      if (i >= lim) begin
         num_errors++;
         $display("mismatch at %0t: wait ran out", $time);
         give_verdict();
      end
   endtask : hang
   task automatic push(input logic [7:0] d);
      int i;
      tx_data <= d;
      tx_valid <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (tx_ready === 1'b1)
            break;
      end
      tx_valid <= 1'b0;
      hang(i, 100);
      @(posedge clk);
   endtask : push
   task automatic wait_starts(input int want);
      int i;
      for (i = 0; i < 400 && n_start < want; i++)
         @(posedge clk);
      hang(i, 400);
   endtask : wait_starts
   task automatic rts_at(input logic [4:0] f, input logic fd, input logic exp);
      rx_stat <= {f, trg, fd};
      repeat (4) @(posedge clk);
      check({7'h00, rts_n_q}, {7'h00, exp});
   endtask : rts_at
   task automatic t_plain();
      b = n_start;
      push(8'hA5);
      push(8'h3C);
      wait_starts(b + 2);
      check(last, 8'h3C);
   endtask : t_plain
   task automatic t_auto();
      modem_ctl <= 2'h2;
      repeat (5) @(posedge clk);
      b = n_start;
      n_delta = 0;
      push(8'h5A);
      repeat (20) @(posedge clk);
      check(8'(n_start - b), 8'h00);
      check({7'h00, rts_n_q}, 8'h01);
      cts_hold <= 1'b0;
      wait_starts(b + 1);
      check(last, 8'h5A);
      check(8'(n_delta), 8'h00);
   endtask : t_auto
   task automatic t_rts();
      logic [4:0] lv[3] = '{5'h01, 5'h04, 5'h08};
      modem_ctl <= 2'h3;
      for (int k = 0; k < 3; k++) begin
         trg = 2'(k);
         rts_at(lv[k] - 5'h01, 1'b0, 1'b0);
         rts_at(lv[k], 1'b0, 1'b1);
         rts_at(5'h01, 1'b0, 1'b1);
         rts_at(5'h00, 1'b0, 1'b0);
      end
      trg = 2'h3;
      rts_at(5'h0F, 1'b0, 1'b0);
      rts_at(5'h0F, 1'b1, 1'b1);
      rts_at(5'h0E, 1'b0, 1'b0);
      rts_at(5'h10, 1'b0, 1'b1);
      rts_at(5'h0F, 1'b0, 1'b0);
   endtask : t_rts
   task automatic t_fill();
      modem_ctl <= 2'h2;
      cts_hold <= 1'b1;
      repeat (8) @(posedge clk);
      b = n_start;
      for (int i = 0; i < 32; i++)
         push(8'(i));
      check({7'h00, tx_ready}, 8'h00);
      cts_hold <= 1'b0;
      wait_starts(b + 32);
      check(last, 8'h1F);
   endtask : t_fill
   task automatic t_pause();
      modem_ctl <= 2'h3;
      cts_hold <= 1'b0;
      repeat (8) @(posedge clk);
      b = n_start;
      push(8'h11);
      // far end pauses during the first frame, well before its stop bit
      cts_hold <= 1'b1;
      push(8'h22);
      push(8'h33);
      repeat (20) @(posedge clk);
      check(8'(n_start - b), 8'h01);
      cts_hold <= 1'b0;
      wait_starts(b + 3);
      check(last, 8'h33);
   endtask : t_pause
   task automatic t_delta();
      modem_ctl <= 2'h0;
      repeat (4) @(posedge clk);
      n_delta = 0;
      cts_hold <= 1'b1;
      repeat (8) @(posedge clk);
      check(8'(n_delta), 8'h01);
   endtask : t_delta
   initial begin
      rst = 1'b1;
      modem_ctl = 2'h0;
      rx_stat = '0;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      cts_hold = 1'b1;
      trg = 2'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_plain();
      t_auto();
      t_rts();
      t_pause();
      t_fill();
      t_delta();
      give_verdict();
   end
endmodule : uafc_top_bench
